// ### common/plpc_pkg.sv
// Package for the page-level protection checker: fields, structs, states, offsets
package plpc_pkg;

	// Entry flag positions
	localparam int ENTRY_RW_BIT = 1;
	localparam int ENTRY_US_BIT = 2;
	localparam int ENTRY_W = 32;

	// Privilege level encoding
	localparam logic [1:0] PL_USER = 2'h3;
	localparam logic [1:0] PL_ZERO = 2'h0;

	// Register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_CLEAR = 4'h2;
	localparam logic [3:0] REG_ENABLE = 4'h3;
	localparam logic [3:0] REG_CAUSE = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h5;

	// Reset values
	localparam logic CTRL_WP_RST = 1'b0;
	localparam logic [1:0] IRQ_EN_RST = 2'h0;

	// Status bit positions
	localparam int ST_PAGE_FAULT = 0;
	localparam int ST_SEG_FAULT = 1;
	localparam int ST_W = 2;

	// Cycle counts
	localparam int CHECK_LATENCY_CYC = 1;

	// One reference presented for checking
	typedef struct packed {
		logic [ENTRY_W-1:0] dir_entry;
		logic [ENTRY_W-1:0] tbl_entry;
		logic [1:0] current_privilege_level;
		logic write;
		logic desc_table_access;
		logic inner_stack_access;
		logic seg_fault;
	} plpc_req_t;

	// Verdict of one reference
	typedef struct packed {
		logic allow;
		logic page_fault_exception;
		logic seg_blocked;
		logic fault_write;
		logic fault_user;
		logic fault_priv;
	} plpc_resp_t;

	// Checker state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DONE = 2'b10
	} plpc_state_t;

endpackage : plpc_pkg

// ### src/plpc_checker.sv
// Page-level protection checker with register port and interrupt
// Function
// - Check completes before cycle; violation blocks, faults
// - Read/write bit 1, user bit 2
// - Check directory and table entries both
// - Privilege flag 0 supervisor, 1 user
// - Levels 0-2 supervisor, level 3 user
// - Supervisor reaches all; user needs user page
// - Access flag 0 read-only, 1 read/write
// - Write-protect clear: supervisor writes everything
// - User writes need user and read/write
// - User reads user pages; supervisor pages fault
// - Write-protect set: supervisor read-only writes fault
// - Combined privilege user only if both user
// - Combined access read/write only if both
// - Descriptor table accesses checked as level 0
// - Inner stack accesses checked as level 0
// - Segment first; segment fault suppresses page fault
// - Page permissions never override segment denial
`timescale 1ns/10ps
module plpc_checker
	import plpc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire plpc_req_t req,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic resp_valid,
	output plpc_resp_t resp,
	output logic irq
);

	// Control and interrupt state
	logic wp;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] irq_en;
	logic [15:0] fault_count;
	plpc_resp_t last_fault;
	plpc_state_t state;
	plpc_state_t next_state;

	wire logic dir_rw = req.dir_entry[ENTRY_RW_BIT];
	wire logic dir_us = req.dir_entry[ENTRY_US_BIT];
	wire logic tbl_rw = req.tbl_entry[ENTRY_RW_BIT];
	wire logic tbl_us = req.tbl_entry[ENTRY_US_BIT];

	wire logic comb_user = dir_us & tbl_us;
	wire logic comb_rw = dir_rw & tbl_rw;

	wire logic force_pl0 = req.desc_table_access | req.inner_stack_access;
	wire logic [1:0] eff_pl = force_pl0 ? PL_ZERO : req.current_privilege_level;
	wire logic user_mode = (eff_pl == PL_USER);

	wire logic priv_fail = user_mode & ~comb_user;
	wire logic user_wr_fail = user_mode & req.write & ~comb_rw;
	wire logic sup_wr_fail = ~user_mode & wp & req.write & ~comb_rw;
	wire logic page_viol = priv_fail | user_wr_fail | sup_wr_fail;

	wire logic pf = page_viol & ~req.seg_fault;
	wire logic allow_now = ~page_viol & ~req.seg_fault;

	// Register decode
	wire logic wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
	wire logic wr_clear = reg_wr & (reg_addr == REG_CLEAR);
	wire logic wr_enable = reg_wr & (reg_addr == REG_ENABLE);
	wire logic [ST_W-1:0] events = req_valid ? {req.seg_fault, pf} : '0;

	// Read mux, unmapped reads give zero
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		case (reg_addr)
			REG_CTRL: next_rdata = {31'h0, wp};
			REG_STATUS: next_rdata = {30'h0, status};
			REG_ENABLE: next_rdata = {30'h0, irq_en};
			REG_CAUSE: next_rdata = {26'h0, last_fault};
			REG_COUNT: next_rdata = {16'h0, fault_count};
			default: next_rdata = 32'h0;
		endcase
	end

	// Verdict presence tracking
	always_comb begin
		case (state)
			ST_IDLE: next_state = req_valid ? ST_DONE : ST_IDLE;
			ST_DONE: next_state = req_valid ? ST_DONE : ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Write-protect control, clear after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			wp <= CTRL_WP_RST;
			irq_en <= IRQ_EN_RST;
		end else begin
			if (wr_ctrl) begin
				wp <= reg_wdata[0];
			end
			if (wr_enable) begin
				irq_en <= reg_wdata[ST_W-1:0];
			end
		end
	end

	// Sticky status; a new event wins over the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			status <= '0;
		end else begin
			status <= (status & ~(wr_clear ? reg_wdata[ST_W-1:0] : '0)) | events;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			last_fault <= '0;
			fault_count <= 16'h0;
		end else if (req_valid & pf) begin
			last_fault <= {1'b0, 1'b1, 1'b0, req.write, user_mode, priv_fail};
			fault_count <= fault_count + 16'h1;
		end
	end

	// verdict registered, one cycle after request
	// single fault with kind and mode
	always_ff @(posedge clk) begin
		if (srst) begin
			resp_valid <= 1'b0;
			resp <= '0;
		end else begin
			resp_valid <= req_valid;
			resp.allow <= req_valid & allow_now;
			resp.page_fault_exception <= req_valid & pf;
			resp.seg_blocked <= req_valid & req.seg_fault;
			resp.fault_write <= req_valid & req.write;
			resp.fault_user <= req_valid & user_mode;
			resp.fault_priv <= req_valid & priv_fail;
		end
	end

	// Register read data and interrupt output
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 32'h0;
			irq <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
			irq <= |(status & irq_en);
		end
	end

endmodule : plpc_checker

// ### bench/plpc_pipe_model.sv
// Pipeline model feeding random references
`timescale 1ns/10ps
module plpc_pipe_model
	import plpc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic en,
	output plpc_req_t req,
	output logic req_valid
);
	int seed = 95;
	logic [95:0] r;
	// Random gaps and back-to-back references
	always @(posedge clk) begin
		r = {$random(seed), $random(seed), $random(seed)};
		req_valid <= en & !srst & r[95];
		req <= r[$bits(plpc_req_t)-1:0];
	end
endmodule : plpc_pipe_model

// ### bench/plpc_checker_chk.sv
// Assertions on the checker verdict port
`timescale 1ns/10ps
module plpc_checker_chk
	import plpc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire plpc_req_t req,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic resp_valid,
	input wire plpc_resp_t resp,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Effective mode and combined flags
	wire ok = req_valid & !req.seg_fault;
	wire u = req.current_privilege_level == PL_USER && !req.desc_table_access && !req.inner_stack_access;
	wire cu = req.dir_entry[ENTRY_US_BIT] & req.tbl_entry[ENTRY_US_BIT];
	wire crw = req.dir_entry[ENTRY_RW_BIT] & req.tbl_entry[ENTRY_RW_BIT];
	property p_lat; req_valid |=> resp_valid; endproperty
	a_lat: assert property (p_lat) else $error("verdict late");
	property p_seg; req_valid && req.seg_fault |=> resp.seg_blocked && !resp.allow && !resp.page_fault_exception;
	endproperty
	a_seg: assert property (p_seg) else $error("segment denial lost");
	property p_ovr; ok && (req.desc_table_access || req.inner_stack_access) && !req.write |=> resp.allow && !resp.fault_user;
	endproperty
	a_ovr: assert property (p_ovr) else $error("level 0 override");
	property p_user; req_valid && u |=> resp.fault_user; endproperty
	a_user: assert property (p_user) else $error("user mode missed");
	property p_sup; ok && !u && !req.write |=> resp.allow; endproperty
	a_sup: assert property (p_sup) else $error("supervisor read blocked");
	property p_upr; ok && u && !cu |=> resp.page_fault_exception && resp.fault_priv; endproperty
	a_upr: assert property (p_upr) else $error("user reached supervisor page");
	property p_uwr; ok && u && req.write && !crw |=> resp.page_fault_exception; endproperty
	a_uwr: assert property (p_uwr) else $error("user wrote read-only page");
	property p_wr; req_valid |=> resp.fault_write == $past(req.write); endproperty
	a_wr: assert property (p_wr) else $error("access kind wrong");
endmodule : plpc_checker_chk

// ### bench/tb.sv
// Testbench: random references, registers and interrupt
`timescale 1ns/10ps
module tb import plpc_pkg::*;;
	logic clk = 0, srst = 1, en = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, wp_m = 0, req_valid, resp_valid, irq;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata;
	plpc_req_t req;
	plpc_resp_t resp;
	int fails = 0, tests_run = 0;
	plpc_resp_t eq[$];
	logic [31:0] rq[$];
	plpc_checker uut (.clk, .srst, .req_valid, .req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.resp_valid, .resp, .irq);
	plpc_pipe_model pm (.clk, .srst, .en, .req, .req_valid);
	initial begin
		forever #2 clk = ~clk;
	end
	function automatic plpc_resp_t expect_f(plpc_req_t r, logic wp);
		logic u, cu, v;
		u = r.current_privilege_level == PL_USER && !r.desc_table_access && !r.inner_stack_access;
		cu = r.dir_entry[ENTRY_US_BIT] & r.tbl_entry[ENTRY_US_BIT];
		v = (u & !cu) | (r.write & !(r.dir_entry[ENTRY_RW_BIT] & r.tbl_entry[ENTRY_RW_BIT]) & (u | wp));
		return {!v & !r.seg_fault, v & !r.seg_fault, r.seg_fault, r.write, u, u & !cu};
	endfunction : expect_f
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 0;
	endtask : rd
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Oldest note meets each verdict, then this edge's request is noted
	always @(posedge clk) begin
		if (resp_valid) chk(resp, eq.size() ? eq.pop_front() : '1);
		if (rd_d) chk(reg_rdata, rq.pop_front());
		rd_d <= reg_rd;
		if (req_valid && !srst) eq.push_back(expect_f(req, wp_m));
		if (srst) wp_m <= 0;
		else if (reg_wr && reg_addr == REG_CTRL) wp_m <= reg_wdata[0];
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 0;
		rd(REG_CTRL, 0);
		en <= 1;
		repeat (300) @(posedge clk);
		wr(REG_CTRL, 1);
		rd(REG_CTRL, 1);
		repeat (300) @(posedge clk);
		en <= 0;
		rd(4'hf, 0);
		chk(irq, 0);
		wr(REG_ENABLE, 3);
		repeat (3) @(posedge clk);
		chk(irq, 1);
		wr(REG_CLEAR, 3);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		rd(REG_STATUS, 0);
		repeat (3) @(posedge clk);
		chk(eq.size(), 0);
		summarize();
	end
endmodule : tb
bind plpc_checker plpc_checker_chk u_chk (.clk, .srst, .req_valid, .req, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .resp_valid, .resp, .irq);
